// File: hw/touch_key_counter.sv
// How it works
// - Control bits 7..5 pick one of six pads with codes 0..5, and codes 6 and 7 turn counting off.
// - Writing one to control bit 4 starts the counter; the bit is not stored and always reads zero.
// - Hardware sets the regulator-ready flag in control bit 3 and only a software write clears it.
// - Bit 1 of the second control register picks a 32 MHz (0) or 16 MHz (1) counter clock.
// - The 16-bit charge count is read as a high byte and a low byte in two registers.
// - Bit 2 of the regulator register enables the regulator and resets to zero.
// - Bits 1..0 of the regulator register pick the reference, resetting to 00.
// - Bits 3..0 of the capacitance register hold the reference coefficient.
`timescale 1ns/1ps
`default_nettype none
module touch_key_counter #(
  parameter int ADDR_W      = 12,
  parameter int CONV_CYCLES = touch_pkg::CONV_CYCLES
) (
  input  wire logic                    ref_clk,
  input  wire logic                    rst_n,
  input  wire logic                    psel,
  input  wire logic                    penable,
  input  wire logic                    pwrite,
  input  wire logic [ADDR_W-1:0]       paddr,
  input  wire logic [31:0]             pwdata,
  output var  logic [31:0]             prdata,
  output var  logic                    pready,
  output var  logic                    pslverr,
  input  wire logic                    touch_osc,
  input  wire logic                    regulator_settled,
  output var  touch_pkg::analog_ctrl_t analog,
  output var  logic                    irq
);
  logic [2:0]              chan;
  logic                    osc_bit;
  logic                    ready_flag;
  logic                    ovf_flag;
  logic                    clk_sel;
  logic                    mode;
  logic [15:0]             count;
  logic [5:0]              phase;
  logic [15:0]             osc_edges;
  logic                    osc_prev;
  logic [2:0]              status;
  logic [2:0]              mask;
  touch_pkg::conv_state_t  state;

  // Bus decode.
  wire [7:0] idx     = paddr[9:2];
  wire       access  = psel && penable;
  wire       commit  = access && pready;
  wire       wr      = commit && pwrite;
  wire [7:0] wdat    = pwdata[7:0];
  wire       hit_map = (idx >= touch_pkg::IDX_CTRL2) && (idx <= touch_pkg::IDX_MASK);
  wire       aligned = (paddr[1:0] == 2'h0) && (paddr[ADDR_W-1:10] == '0);
  wire       mapped  = hit_map && aligned;
  wire       wr_ctrl2  = wr && mapped && (idx == touch_pkg::IDX_CTRL2);
  wire       wr_ctrl   = wr && mapped && (idx == touch_pkg::IDX_CTRL);
  wire       wr_reg    = wr && mapped && (idx == touch_pkg::IDX_REG);
  wire       wr_charge = wr && mapped && (idx == touch_pkg::IDX_CHARGE);
  wire       wr_cap    = wr && mapped && (idx == touch_pkg::IDX_CAP);
  wire       wr_status = wr && mapped && (idx == touch_pkg::IDX_STATUS);
  wire       wr_mask   = wr && mapped && (idx == touch_pkg::IDX_MASK);

  // Channel and start decode.
  wire       chan_ok   = (chan <= touch_pkg::CH_LAST);
  wire [2:0] new_chan  = wdat[touch_pkg::CTRL_CH_LSB +: 3];
  wire       new_ok    = (new_chan <= touch_pkg::CH_LAST);
  wire       busy      = (state != touch_pkg::IDLE);
  // A start with counting disabled or during a conversion is ignored.
  wire       start     = wr_ctrl && wdat[touch_pkg::CTRL_START] && new_ok && !busy;

  // Counter clock tick from a 50 MHz phase accumulator.
  wire [5:0] step      = clk_sel ? touch_pkg::SLOW_MHZ : touch_pkg::FAST_MHZ;
  wire [6:0] phase_sum = {1'b0, phase} + {1'b0, step};
  wire       tick      = (phase_sum >= {1'b0, touch_pkg::SYS_MHZ});
  wire [6:0] phase_wrp = phase_sum - {1'b0, touch_pkg::SYS_MHZ};
  wire [5:0] next_phase = tick ? phase_wrp[5:0] : phase_sum[5:0];

  // Conversion progress.
  wire       running   = (state == touch_pkg::RUN);
  wire       osc_edge  = touch_osc && !osc_prev && running;
  wire       last_edge = osc_edge && (osc_edges == 16'(CONV_CYCLES - 1));
  wire       wrap      = running && tick && (count == 16'hffff);
  wire       finish    = (state == touch_pkg::DONE);

  // Regulator ready: set wins over the software clear.
  // The flag is set on every cycle of the settled condition, so a clear while the regulator stays settled
  // has no effect; the status event fires only on the rising edge of the flag.
  wire       rdy_cond  = analog.regulator_enable && regulator_settled;
  wire       rdy_set   = rdy_cond && !ready_flag;
  wire       rdy_clr   = wr_ctrl && !wdat[touch_pkg::CTRL_READY];
  wire       next_ready = rdy_cond || (ready_flag && !rdy_clr);

  // Overflow flag: cleared by a new start, a wrap in the same cycle still sets it.
  wire       next_ovf  = wrap || (ovf_flag && !start);

  // Interrupt status, write one to clear, set wins.
  wire [2:0] events;
  assign events[touch_pkg::ST_DONE]  = finish;
  assign events[touch_pkg::ST_OVF]   = wrap;
  assign events[touch_pkg::ST_READY] = rdy_set;
  wire [2:0] st_clr      = wr_status ? wdat[2:0] : 3'h0;
  wire [2:0] next_status = events | (status & ~st_clr);
  wire       next_irq    = |(next_status & mask);

  // Next state.
  touch_pkg::conv_state_t next_state;
  always_comb begin
    case (state)
      touch_pkg::IDLE: next_state = start ? touch_pkg::RUN : touch_pkg::IDLE;
      touch_pkg::RUN:  next_state = last_edge ? touch_pkg::DONE : touch_pkg::RUN;
      touch_pkg::DONE: next_state = touch_pkg::IDLE;
      default:         next_state = touch_pkg::IDLE;
    endcase
  end

  // Pad decode for the analog side.
  function automatic logic [5:0] pad_decode(input logic [2:0] ch);
    pad_decode = (ch <= touch_pkg::CH_LAST) ? 6'(6'h01 << ch) : 6'h00;
  endfunction : pad_decode

  // Read data.
  logic [7:0] rd_byte;
  always_comb begin
    rd_byte = 8'h00;
    case (idx)
      touch_pkg::IDX_CTRL2:  rd_byte = {busy, 5'h00, clk_sel, mode};
      touch_pkg::IDX_CTRL:   rd_byte = {chan, 1'b0, ready_flag, ovf_flag, 1'b0, osc_bit};
      touch_pkg::IDX_CNT_HI: rd_byte = count[15:8];
      touch_pkg::IDX_CNT_LO: rd_byte = count[7:0];
      touch_pkg::IDX_REG:    rd_byte = {5'h00, analog.regulator_enable, analog.regulator_ref};
      touch_pkg::IDX_CHARGE: rd_byte = analog.charge_setting;
      touch_pkg::IDX_CAP:    rd_byte = {4'h0, analog.cap_coef};
      touch_pkg::IDX_STATUS: rd_byte = {5'h00, status};
      touch_pkg::IDX_MASK:   rd_byte = {5'h00, mask};
      default:               rd_byte = 8'h00;
    endcase
  end

  // APB slave with one wait state; data and error are registered.
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      pready  <= 1'b0;
      prdata  <= 32'h0;
      pslverr <= 1'b0;
    end else begin
      pready  <= access && !pready;
      prdata  <= (access && !pready && mapped) ? {24'h0, rd_byte} : 32'h0;
      pslverr <= access && !pready && !mapped;
    end
  end

  // Control registers.
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      chan    <= touch_pkg::CH_RESET;
      osc_bit <= 1'b0;
      clk_sel <= 1'b0;
      mode    <= 1'b0;
      mask    <= touch_pkg::ST_RESET;
    end else begin
      if (wr_ctrl) begin
        chan    <= new_chan;
        osc_bit <= wdat[touch_pkg::CTRL_OSC];
      end
      if (wr_ctrl2) begin
        clk_sel <= wdat[touch_pkg::CTRL2_CLKSEL];
        mode    <= wdat[touch_pkg::CTRL2_MODE];
      end
      if (wr_mask) begin
        mask <= wdat[2:0];
      end
    end
  end

  // Analog controls, all registered.
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      analog.pad_enable       <= 6'h00;
      analog.osc_enable       <= 1'b0;
      analog.regulator_enable <= 1'b0;
      analog.regulator_ref    <= touch_pkg::REF_RESET;
      analog.cap_coef         <= touch_pkg::CAP_RESET;
      analog.charge_setting   <= touch_pkg::CHG_RESET;
    end else begin
      if (wr_ctrl) begin
        analog.pad_enable <= pad_decode(new_chan);
        analog.osc_enable <= wdat[touch_pkg::CTRL_OSC] && new_ok;
      end
      if (wr_reg) begin
        analog.regulator_enable <= wdat[touch_pkg::REG_EN];
        analog.regulator_ref    <= wdat[1:0];
      end
      if (wr_charge) begin
        analog.charge_setting <= wdat;
      end
      if (wr_cap) begin
        analog.cap_coef <= wdat[3:0];
      end
    end
  end

  // Conversion engine and flags.
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      state      <= touch_pkg::IDLE;
      phase      <= 6'h00;
      count      <= 16'h0000;
      osc_edges  <= 16'h0000;
      osc_prev   <= 1'b0;
      ready_flag <= 1'b0;
      ovf_flag   <= 1'b0;
      status     <= touch_pkg::ST_RESET;
      irq        <= 1'b0;
    end else begin
      state      <= next_state;
      phase      <= next_phase;
      osc_prev   <= touch_osc;
      ready_flag <= next_ready;
      ovf_flag   <= next_ovf;
      status     <= next_status;
      irq        <= next_irq;
      if (start) begin
        count     <= 16'h0000;
        osc_edges <= 16'h0000;
      end else if (running) begin
        count     <= tick ? count + 16'h0001 : count;
        osc_edges <= osc_edge ? osc_edges + 16'h0001 : osc_edges;
      end
    end
  end

  // Checks.
  sequence start_req_s;
    start;
  endsequence
  sequence run_begun_s;
    ##1 (state == touch_pkg::RUN);
  endsequence

  property start_runs_p;
    @(posedge ref_clk) disable iff (!rst_n) start_req_s |-> run_begun_s;
  endproperty
  start_runs_a: assert property (start_runs_p) else $error("start did not begin a conversion");

  disabled_start_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (wr_ctrl && new_chan[2] && new_chan[1] && !busy) |=> (state == touch_pkg::IDLE))
    else $error("start accepted with counting disabled");

  pad_onehot_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    $countones(analog.pad_enable) <= 1)
    else $error("more than one pad enabled");

  done_clears_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (state == touch_pkg::DONE) |=> (state == touch_pkg::IDLE) && status[touch_pkg::ST_DONE])
    else $error("busy did not clear at the end of conversion");

  ready_hold_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (ready_flag && !rdy_clr) |=> ready_flag)
    else $error("ready flag lost without a software clear");

  ready_set_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (analog.regulator_enable && regulator_settled) |=> ready_flag)
    else $error("ready flag not set");

  clk_rate_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (clk_sel && tick && !wr_ctrl2) ##1 !wr_ctrl2 |-> !tick ##1 !tick)
    else $error("slow counter clock ticks too often");

  count_step_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (running && !start && tick) |=> (count == 16'($past(count) + 16'h0001)))
    else $error("count did not step on a counter tick");

  overflow_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    wrap |=> ovf_flag && (count == 16'h0000))
    else $error("wrap did not set overflow");

  count_read_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (access && !pready && mapped && idx == touch_pkg::IDX_CNT_HI)
      |=> (prdata[7:0] == $past(count[15:8])))
    else $error("high count byte read wrong");

  reg_field_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    wr_reg |=> (analog.regulator_ref == $past(wdat[1:0]))
      && (analog.regulator_enable == $past(wdat[touch_pkg::REG_EN])))
    else $error("regulator control not taken");

  irq_level_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    ##1 (irq == $past(next_irq)))
    else $error("interrupt does not follow masked status");

  // Read data is registered, which costs one wait state on every transfer but keeps the
  // read mux out of the bus timing path.
  sequence bus_wait_s;
    access && !pready;
  endsequence
  sequence bus_answer_s;
    ##1 pready ##1 !pready;
  endsequence

  wait_state_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    bus_wait_s |-> bus_answer_s)
    else $error("bus answer not after one wait state");

  unmapped_err_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (access && !pready && !mapped) |=> pslverr && (prdata == 32'h0))
    else $error("unmapped access not refused");

  pad_off_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (wr_ctrl && !new_ok) |=> (analog.pad_enable == 6'h00) && !analog.osc_enable)
    else $error("pad or oscillator left on with counting disabled");

  busy_start_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (wr_ctrl && running && !last_edge && !wrap) |=> running && (count >= $past(count)))
    else $error("start during a conversion disturbed it");

  ready_win_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (rdy_cond && rdy_clr) |=> ready_flag)
    else $error("ready clear won over a settled regulator");

  ovf_clear_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    start |=> !ovf_flag)
    else $error("overflow flag not cleared by a new start");

  // The count is frozen while idle, so the two byte reads after a conversion agree.
  count_hold_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (!busy && !start) |=> (count == $past(count)))
    else $error("count moved while idle");

  status_win_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    ##1 ((status & $past(events)) == $past(events)))
    else $error("status event lost to a clear");
endmodule : touch_key_counter
`default_nettype wire

// File: include/touch_pkg.sv
`default_nettype none
package touch_pkg;
  // Register indices; the APB byte address is four times the index.
  localparam logic [7:0] IDX_CTRL2    = 8'h20;
  localparam logic [7:0] IDX_CTRL     = 8'h21;
  localparam logic [7:0] IDX_CNT_HI   = 8'h22;
  localparam logic [7:0] IDX_CNT_LO   = 8'h23;
  localparam logic [7:0] IDX_REG      = 8'h24;
  localparam logic [7:0] IDX_CHARGE   = 8'h25;
  localparam logic [7:0] IDX_CAP      = 8'h26;
  localparam logic [7:0] IDX_STATUS   = 8'h27;
  localparam logic [7:0] IDX_MASK     = 8'h28;

  localparam int CTRL2_BUSY   = 7;
  localparam int CTRL2_CLKSEL = 1;
  localparam int CTRL2_MODE   = 0;
  localparam int CTRL_CH_LSB  = 5;
  localparam int CTRL_START   = 4;
  localparam int CTRL_READY   = 3;
  localparam int CTRL_OVF     = 2;
  localparam int CTRL_OSC     = 0;
  localparam int REG_EN       = 2;
  localparam int ST_DONE      = 0;
  localparam int ST_OVF       = 1;
  localparam int ST_READY     = 2;

  localparam logic [2:0] CH_LAST     = 3'h5;
  localparam logic [1:0] REF_RESET   = 2'h0;
  localparam logic [3:0] CAP_RESET   = 4'h0;
  localparam logic [7:0] CHG_RESET   = 8'h00;
  localparam logic [2:0] ST_RESET    = 3'h0;
  localparam logic [2:0] CH_RESET    = 3'h7;

  // Counter clock is made from the 50 MHz system clock by a phase accumulator.
  localparam logic [5:0] SYS_MHZ     = 6'd50;
  localparam logic [5:0] FAST_MHZ    = 6'd32;
  localparam logic [5:0] SLOW_MHZ    = 6'd16;
  localparam int         CONV_CYCLES = 16;

  typedef struct packed {
    logic [5:0] pad_enable;
    logic       osc_enable;
    logic       regulator_enable;
    logic [1:0] regulator_ref;
    logic [3:0] cap_coef;
    logic [7:0] charge_setting;
  } analog_ctrl_t;

  typedef enum logic [2:0] {
    IDLE = 3'b001,
    RUN  = 3'b010,
    DONE = 3'b100
  } conv_state_t;
endpackage : touch_pkg
`default_nettype wire

// File: testbench/touch_pad_model.sv
`timescale 1ns/1ps
`default_nettype none
module touch_pad_model #(
  parameter int HALF   = 40,
  parameter int SETTLE = 30
) (
  input  wire logic                    ref_clk,
  input  wire touch_pkg::analog_ctrl_t analog,
  output var  logic                    touch_osc,
  output var  logic                    regulator_settled
);
  int osc_cnt = 0;
  int reg_cnt = 0;
  // The pad oscillator swings only with a pad and its oscillator on, and stands low otherwise.
  always @(posedge ref_clk) begin
    if (analog.osc_enable && analog.pad_enable != 6'h00) begin
      osc_cnt <= (osc_cnt == HALF - 1) ? 0 : osc_cnt + 1;
      if (osc_cnt == HALF - 1) begin
        touch_osc <= ~touch_osc;
      end
    end else begin
      osc_cnt <= 0;
      touch_osc <= 1'b0;
    end
    reg_cnt <= analog.regulator_enable ? reg_cnt + 1 : 0;
    regulator_settled <= analog.regulator_enable && reg_cnt >= SETTLE;
  end
endmodule : touch_pad_model
`default_nettype wire

// File: testbench/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic                    ref_clk;
  logic                    rst_n;
  logic                    psel;
  logic                    penable;
  logic                    pwrite;
  logic [11:0]             paddr;
  logic [31:0]             pwdata;
  logic [31:0]             prdata;
  logic                    pready;
  logic                    pslverr;
  logic                    touch_osc;
  logic                    regulator_settled;
  touch_pkg::analog_ctrl_t analog;
  logic                    irq;
  logic [31:0]             rd;
  logic                    err;
  int                      error_cnt = 0;
  int                      check_count = 0;
  int                      cyc = 0;

  touch_key_counter #(.ADDR_W(12), .CONV_CYCLES(4)) touch_key_counter_i (
    .ref_clk(ref_clk), .rst_n(rst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .touch_osc(touch_osc),
    .regulator_settled(regulator_settled), .analog(analog), .irq(irq));
  touch_pad_model #(.HALF(40), .SETTLE(30)) touch_pad_model_i (
    .ref_clk(ref_clk), .analog(analog), .touch_osc(touch_osc),
    .regulator_settled(regulator_settled));

  task automatic summarize();
    $display("checks %0d errors %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : summarize

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  // One idle cycle separates transfers, so no strobe is driven twice at one edge.
  task automatic apb(input logic w, input logic [7:0] idx, input logic [7:0] d);
    @(posedge ref_clk);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= {2'h0, idx, 2'h0};
    pwdata <= {24'h0, d};
    @(posedge ref_clk);
    penable <= 1'b1;
    // Pready and read data are taken as they stand at the edge, before its updates.
    do begin
      @(posedge ref_clk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    apb(1'b1, idx, d);
  endtask : wr

  task automatic rchk(input string name, input logic [7:0] idx, input logic [7:0] exp);
    apb(1'b0, idx, 8'h00);
    check(name, rd, {24'h0, exp});
  endtask : rchk

  task automatic reset_values();
    @(negedge ref_clk);
    check("analog", {10'h0, analog}, 32'h0);
    rchk("ctrl2", touch_pkg::IDX_CTRL2, 8'h00);
    rchk("ctrl", touch_pkg::IDX_CTRL, 8'he0);
    rchk("regulator", touch_pkg::IDX_REG, 8'h00);
    rchk("cap", touch_pkg::IDX_CAP, 8'h00);
    wr(touch_pkg::IDX_CTRL, 8'h08);
    rchk("flag write", touch_pkg::IDX_CTRL, 8'h00);
    apb(1'b0, 8'h30, 8'h00);
    check("unmapped err", {31'h0, err}, 32'h1);
    check("unmapped data", rd, 32'h0);
  endtask : reset_values

  task automatic regulator_up();
    wr(touch_pkg::IDX_MASK, 8'h04);
    wr(touch_pkg::IDX_CTRL, 8'h00);
    // The low-speed oscillator is taken as running from power-up.
    wr(touch_pkg::IDX_REG, 8'h04);
    while (regulator_settled !== 1'b1) begin
      @(negedge ref_clk);
    end
    repeat (3) @(negedge ref_clk);
    check("irq ready", {31'h0, irq}, 32'h1);
    rchk("ready flag", touch_pkg::IDX_CTRL, 8'h08);
    rchk("status", touch_pkg::IDX_STATUS, 8'h04);
    wr(touch_pkg::IDX_STATUS, 8'h04);
    repeat (2) @(negedge ref_clk);
    check("irq clear", {31'h0, irq}, 32'h0);
    wr(touch_pkg::IDX_CHARGE, 8'h40);
    wr(touch_pkg::IDX_CAP, 8'h08);
    @(negedge ref_clk);
    check("charge", {24'h0, analog.charge_setting}, 32'h40);
    check("coef", {28'h0, analog.cap_coef}, 32'h8);
    // Code 01 is reserved, so only the three usable references are set.
    for (int r = 0; r < 4; r += (r == 0) ? 2 : 1) begin
      wr(touch_pkg::IDX_REG, 8'h04 | r[7:0]);
      @(negedge ref_clk);
      check("ref", {30'h0, analog.regulator_ref}, r);
    end
    rchk("regulator", touch_pkg::IDX_REG, 8'h07);
  endtask : regulator_up

  task automatic channel_codes();
    for (int c = 0; c < 8; c++) begin
      wr(touch_pkg::IDX_CTRL, {c[2:0], 5'h08});
      @(negedge ref_clk);
      check("pad", {26'h0, analog.pad_enable}, (c < 6) ? (32'h1 << c) : 32'h0);
    end
  endtask : channel_codes

  // A wrap needs over 100k cycles of counting, so overflow is only seen to stay clear.
  task automatic conversion(input logic sel);
    int          t0;
    int          exp;
    logic [15:0] cnt;
    wr(touch_pkg::IDX_CTRL2, {6'h00, sel, 1'b0});
    wr(touch_pkg::IDX_CTRL, 8'h48);
    repeat (50) @(posedge ref_clk);
    wr(touch_pkg::IDX_CTRL, 8'h49);
    repeat (1000) @(posedge ref_clk);
    check("osc", {31'h0, analog.osc_enable}, 32'h1);
    wr(touch_pkg::IDX_MASK, 8'h01);
    wr(touch_pkg::IDX_CTRL, 8'h59);
    t0 = cyc;
    rchk("busy", touch_pkg::IDX_CTRL2, {6'h20, sel, 1'b0});
    // A second start while busy must not restart the count checked below.
    wr(touch_pkg::IDX_CTRL, 8'h59);
    while (irq !== 1'b1) begin
      @(negedge ref_clk);
    end
    exp = (cyc - t0) * (sel ? 16 : 32) / 50;
    apb(1'b0, touch_pkg::IDX_CNT_HI, 8'h00);
    cnt[15:8] = rd[7:0];
    apb(1'b0, touch_pkg::IDX_CNT_LO, 8'h00);
    cnt[7:0] = rd[7:0];
    check("count", {31'h0, (cnt >= exp - 4) && (cnt <= exp + 1)}, 32'h1);
    rchk("idle", touch_pkg::IDX_CTRL2, {6'h00, sel, 1'b0});
    rchk("start clear", touch_pkg::IDX_CTRL, 8'h49);
    rchk("done", touch_pkg::IDX_STATUS, 8'h01);
    wr(touch_pkg::IDX_STATUS, 8'h01);
    repeat (2) @(negedge ref_clk);
    check("irq done clear", {31'h0, irq}, 32'h0);
  endtask : conversion

  task automatic refused_starts();
    wr(touch_pkg::IDX_MASK, 8'h00);
    wr(touch_pkg::IDX_CTRL, 8'h59);
    repeat (600) @(negedge ref_clk);
    check("masked irq", {31'h0, irq}, 32'h0);
    rchk("masked status", touch_pkg::IDX_STATUS, 8'h01);
    wr(touch_pkg::IDX_STATUS, 8'h01);
    wr(touch_pkg::IDX_CTRL, 8'hf8);
    rchk("off busy", touch_pkg::IDX_CTRL2, 8'h02);
    check("off osc", {31'h0, analog.osc_enable}, 32'h0);
  endtask : refused_starts

  task automatic regulator_restart();
    wr(touch_pkg::IDX_CTRL, 8'h40);
    rchk("ready kept", touch_pkg::IDX_CTRL, 8'h48);
    wr(touch_pkg::IDX_REG, 8'h00);
    // More than 50 us off before the regulator is started again.
    repeat (2600) @(posedge ref_clk);
    wr(touch_pkg::IDX_CTRL, 8'h40);
    rchk("ready clear", touch_pkg::IDX_CTRL, 8'h40);
    wr(touch_pkg::IDX_REG, 8'h04);
    while (regulator_settled !== 1'b1) begin
      @(posedge ref_clk);
    end
    repeat (2) @(posedge ref_clk);
    rchk("ready again", touch_pkg::IDX_CTRL, 8'h48);
    rchk("ready event", touch_pkg::IDX_STATUS, 8'h04);
    wr(touch_pkg::IDX_CHARGE, 8'h40);
    wr(touch_pkg::IDX_CAP, 8'h08);
    rchk("charge again", touch_pkg::IDX_CHARGE, 8'h40);
    rchk("coef again", touch_pkg::IDX_CAP, 8'h08);
  endtask : regulator_restart

  initial begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end

  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (cyc == 12000) begin
      error_cnt++;
      summarize();
    end
  end

  initial begin
    rst_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    repeat (10) @(posedge ref_clk);
    rst_n <= 1'b1;
    reset_values();
    regulator_up();
    channel_codes();
    conversion(1'b0);
    conversion(1'b1);
    refused_starts();
    regulator_restart();
    summarize();
  end
endmodule : tb
`default_nettype wire
